// ==== design/rrs_alu.sv ====
// Rotate-right and subtract-with-borrow ALU with AHB-Lite register access
// Operation
// - memory rotate right, bit0 to bit7, no flags
// - rotate right into accumulator, memory kept
// - rotate through carry, written back to memory
// - rotate through carry into accumulator
// - acc minus mem minus not-carry into acc
// - same difference written into memory byte
// - carry cleared on borrow, set otherwise
// - subtraction updates six status flags
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
module rrs_alu (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Results toward core
  output logic [7:0] accumulator,
  output logic [7:0] mem_byte,
  output logic [5:0] flags
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic ov_d;
  logic [7:0] acc_q;
  logic [7:0] mem_q;
  logic [5:0] flags_q;
  logic done_q;
  logic memw_q;
  logic [31:0] hrdata_q;
  rrs_pkg::rrs_op_t op;
  logic go;
  logic [7:0] rot_d;
  logic rot_c;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] sum_d;
  logic addr_ph;

  // Reset release
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Zero-wait slave: only word-sized transfers are taken
  assign addr_ph = hsel && hready && htrans == rrs_pkg::HTRANS_NONSEQ
    && hsize == rrs_pkg::HSIZE_WORD;

  // Bus phase tracking
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Write data phase aimed at one register
  function automatic logic is_wr(input logic pend, input logic [7:0] at,
    input logic [7:0] reg_addr);
    is_wr = pend && at == reg_addr;
  endfunction

  // Codes 0 and 7 are ignored
  function automatic rrs_pkg::rrs_op_t rrs_rrs_op(input logic [2:0] code);
    rrs_rrs_op = (code > 3'b110) ? rrs_pkg::OP_NONE : rrs_pkg::rrs_op_t'(code);
  endfunction

  assign op = is_wr(wr_pend_q, wr_addr_q, rrs_pkg::ADDR_CTRL)
    ? rrs_rrs_op(hwdata[2:0]) : rrs_pkg::OP_NONE;
  assign go = op != rrs_pkg::OP_NONE;

  // Datapath
  always_comb
  begin
    rot_c = flags_q[rrs_pkg::FLAG_C];
    rot_d = mem_q;
    low_diff = {1'b0, acc_q[3:0]} - {1'b0, mem_q[3:0]}
      - {4'h0, ~flags_q[rrs_pkg::FLAG_C]};
    diff = {1'b0, acc_q} - {1'b0, mem_q} - {8'h00, ~flags_q[rrs_pkg::FLAG_C]};
    sum_d = diff[7:0];
    unique case (op)
      rrs_pkg::OP_RR_MEM, rrs_pkg::OP_RR_ACC:
        rot_d = {mem_q[0], mem_q[7:1]};
      rrs_pkg::OP_RRC_MEM, rrs_pkg::OP_RRC_ACC:
      begin
        rot_d = {flags_q[rrs_pkg::FLAG_C], mem_q[7:1]};
        rot_c = mem_q[0];
      end
      default: rot_d = mem_q;
    endcase
  end

  // Signed overflow of the subtraction
  assign ov_d = (acc_q[7] != mem_q[7]) && (sum_d[7] != acc_q[7]);

  // Accumulator and memory byte
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      acc_q <= rrs_pkg::ACC_RST;
      mem_q <= rrs_pkg::MEM_RST;
      memw_q <= 1'b0;
    end
    else if (go)
    begin
      memw_q <= 1'b0;
      unique case (op)
        rrs_pkg::OP_RR_MEM, rrs_pkg::OP_RRC_MEM:
        begin
          mem_q <= rot_d;
          memw_q <= 1'b1;
        end
        rrs_pkg::OP_RR_ACC, rrs_pkg::OP_RRC_ACC:
          acc_q <= rot_d;
        rrs_pkg::OP_SBC_ACC:
          acc_q <= sum_d;
        rrs_pkg::OP_SBC_MEM:
        begin
          mem_q <= sum_d;
          memw_q <= 1'b1;
        end
        default: memw_q <= 1'b0;
      endcase
    end
    else if (is_wr(wr_pend_q, wr_addr_q, rrs_pkg::ADDR_ACC))
      acc_q <= hwdata[7:0];
    else if (is_wr(wr_pend_q, wr_addr_q, rrs_pkg::ADDR_MEM))
      mem_q <= hwdata[7:0];
  end

  // Status flags
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      flags_q <= rrs_pkg::FLAGS_RST;
      done_q <= 1'b0;
    end
    else if (go)
    begin
      done_q <= 1'b1;
      unique case (op)
        rrs_pkg::OP_RRC_MEM, rrs_pkg::OP_RRC_ACC:
          flags_q[rrs_pkg::FLAG_C] <= rot_c;
        rrs_pkg::OP_SBC_ACC, rrs_pkg::OP_SBC_MEM:
        begin
          flags_q[rrs_pkg::FLAG_C] <= ~diff[8];
          flags_q[rrs_pkg::FLAG_AC] <= ~low_diff[4];
          flags_q[rrs_pkg::FLAG_Z] <= sum_d == 8'h00;
          flags_q[rrs_pkg::FLAG_OV] <= ov_d;
          flags_q[rrs_pkg::FLAG_SC] <= sum_d[7] ^ ov_d;
          // Extra zero chains across multi-byte subtracts
          flags_q[rrs_pkg::FLAG_CZ] <= (sum_d == 8'h00)
            && flags_q[rrs_pkg::FLAG_CZ];
        end
        default: flags_q <= flags_q;
      endcase
    end
    else if (is_wr(wr_pend_q, wr_addr_q, rrs_pkg::ADDR_STAT))
    begin
      // Software load of flags also clears done
      flags_q <= hwdata[5:0];
      done_q <= 1'b0;
    end
  end

  // Read data
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      hrdata_q <= 32'h0000_0000;
    else if (addr_ph && !hwrite)
    begin
      unique case (haddr)
        rrs_pkg::ADDR_MEM: hrdata_q <= {24'h00_0000, mem_q};
        rrs_pkg::ADDR_ACC: hrdata_q <= {24'h00_0000, acc_q};
        rrs_pkg::ADDR_STAT: hrdata_q <= {22'h00_0000, memw_q, done_q,
          2'b00, flags_q};
        rrs_pkg::ADDR_RES: hrdata_q <= {16'h0000, mem_q, acc_q};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = hrdata_q;
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accumulator = acc_q;
  assign mem_byte = mem_q;
  assign flags = flags_q;
endmodule

// ==== design/rrs_pkg.sv ====
// Package of opcodes, register offsets and reset values for the rotate/subtract ALU
package rrs_pkg;
  // Operation codes
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_RR_MEM = 3'b001,
    OP_RR_ACC = 3'b010,
    OP_RRC_MEM = 3'b011,
    OP_RRC_ACC = 3'b100,
    OP_SBC_ACC = 3'b101,
    OP_SBC_MEM = 3'b110
  } rrs_op_t;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MEM = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_RES = 8'h10;
  // Status field positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;
  localparam int DONE_BIT = 8;
  localparam int MEMW_BIT = 9;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage

// ==== tb/rrs_alu_asserts.sv ====
// Checker on rotate and subtract results
module rrs_alu_asserts (
  // Clock and reset
  input logic ref_clk,
  input logic nrst,
  // Bus
  input logic [7:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  // Results
  input logic [7:0] accumulator,
  input logic [7:0] mem_byte,
  input logic [5:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go_q;
  logic [2:0] op;
  logic [8:0] rr, rc, df;
  logic [4:0] lo, sub_exp;
  logic ov_e;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge ref_clk)
    go_q <= hwrite && htrans == 2'h2 && haddr == 8'h00;
  assign op = go_q ? hwdata[2:0] : 3'h0;
  assign rr = {mem_byte[0], mem_byte[7:1], flags[0]};
  assign rc = {flags[0], mem_byte};
  assign df = 9'(accumulator) - 9'(mem_byte) - 9'(!flags[0]);
  assign lo = 5'(accumulator[3:0]) - 5'(mem_byte[3:0]) - 5'(!flags[0]);
  assign ov_e = (accumulator[7] != mem_byte[7])
    && (df[7] != accumulator[7]);
  assign sub_exp = {df[7:0] == 8'h00 && flags[5], df[7] ^ ov_e, ov_e,
    df[7:0] == 8'h00, !lo[4]};
  a_rr_mem: assert property (op == 1 |=>
    {mem_byte, flags[0]} == $past(rr)) else $error("rr");
  a_rr_acc: assert property (op == 2 |=>
    {accumulator, flags[0]} == $past(rr)) else $error("rra");
  a_rrc_mem: assert property (op == 3 |=>
    {mem_byte, flags[0]} == $past(rc)) else $error("rrc");
  a_rrc_acc: assert property (op == 4 |=>
    {accumulator, flags[0]} == $past(rc)) else $error("rrca");
  a_flags_kept: assert property (op inside {[1:4]} |=>
    $stable(flags[5:1])) else $error("flags");
  a_sbc_acc: assert property (op == 5 |=>
    {!flags[0], accumulator} == $past(df)) else $error("sbc");
  a_sbc_mem: assert property (op == 6 |=>
    {!flags[0], mem_byte} == $past(df)) else $error("sbcm");
  a_zero_flag: assert property (op == 5 |=>
    flags[2] == (accumulator == 8'h00)) else $error("zero");
  a_mem_kept: assert property (op inside {2, 4, 5} |=>
    $stable(mem_byte)) else $error("mem changed");
  a_acc_kept: assert property (op inside {1, 3, 6} |=>
    $stable(accumulator)) else $error("acc changed");
  a_sub_flags: assert property (op inside {5, 6} |=>
    flags[5:1] == $past(sub_exp)) else $error("sub flags");
  c_rr: cover property (op == 1);
  c_rrc: cover property (op == 3);
  c_rrca: cover property (op == 4);
  c_sbc: cover property (op == 5);
  c_sbcm: cover property (op == 6);
endmodule

// ==== tb/rrs_alu_test.sv ====
// Self-checking bench for the rotate and subtract ALU
module rotate_right_subtract_carry_alu_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, nrst, hwrite, hreadyout, hresp;
  logic [7:0] haddr, accumulator, mem_byte;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, r;
  logic [5:0] flags;
  logic [18:0] got;
  int n_errors = 0;
  int compares = 0;
  // Op, mem, acc, flags in; acc, mem, flags out
  logic [55:0] rows [7] = '{56'h01810000_00c000, 56'h02010001_800101,
    56'h03010000_000001, 56'h04020001_810200, 56'h05050500_ff0500,
    56'h06011001_100f01, 56'h05030301_000307};
  assign got = {accumulator, mem_byte, flags[2:0]};
  rrs_alu u_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .hsel(1'b1),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .accumulator(accumulator),
    .mem_byte(mem_byte),
    .flags(flags)
  );
  rrs_core_model u_bus (
    .ref_clk(ref_clk),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata)
  );
  task automatic chk(input logic ok);
    compares++;
    n_errors += int'(!ok);
    if (!ok)
      $display("BAD %0t mismatch", $time);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  initial
  begin
    #5000 n_errors++;
    print_verdict;
  end
  initial
  begin
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({accumulator, mem_byte, flags, hrdata} === 54'h0);
    chk({hresp, hreadyout} === 2'b01);
    foreach (rows[i])
    begin
      for (int j = 0; j < 4; j++)
        u_bus.xfer(1'b1, 8'(12 - 4 * j), rows[i][24 + 8 * j +: 8], r);
      #1 chk(got === {rows[i][23:8], rows[i][2:0]});
      @(posedge ref_clk);
    end
    u_bus.xfer(1'b1, 8'h00, 8'h01, r);
    u_bus.xfer(1'b1, 8'h00, 8'h01, r);
    u_bus.xfer(1'b0, 8'h10, 8'h00, r);
    chk(r[15:0] === 16'hc000);
    u_bus.xfer(1'b0, 8'h0c, 8'h00, r);
    chk(r === 32'h0000_0307);
    u_bus.xfer(1'b1, 8'h00, 8'h07, r);
    #1 chk(got === {16'h00c0, 3'h7});
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1 chk({accumulator, mem_byte, flags, hrdata} === 54'h0);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    u_bus.xfer(1'b1, 8'h04, 8'h02, r);
    u_bus.xfer(1'b1, 8'h00, 8'h02, r);
    #1 chk(got === {16'h0102, 3'h0});
    print_verdict;
  end
endmodule
bind rrs_alu rrs_alu_asserts u_chk (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .accumulator(accumulator),
  .mem_byte(mem_byte),
  .flags(flags)
);

// ==== tb/rrs_core_model.sv ====
// Core-side bus master issuing operands and op codes
module rrs_core_model (
  // Clock
  input logic ref_clk,
  // Request
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata,
  // Answer
  input logic hready,
  input logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {haddr, htrans, hwrite, hwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? {24'h0, d} : ~hwdata;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule
